/* File: irq_mailbox_pkg.sv */
// Package with register map, field layout and carrier types for the local interrupt and mailbox block.
package irq_mailbox_pkg;

  localparam logic [11:0] IRQ_REG_OFFSET = 12'h4F4;
  localparam logic [11:0] LH_MBOX_OFFSET = 12'h4F8;
  localparam int ADDR_W = 12;

  localparam int EN_LSB = 16;
  localparam int EN_MSB = 25;
  localparam int ST_LSB = 0;
  localparam int ST_MSB = 9;
  localparam int MBOX_IRQ_BIT = 24;
  localparam int NUM_EVT = 10;

  // Event positions, shared by the enable and status fields.
  localparam int EV_LOCAL_FIFO_OVF = 0;
  localparam int EV_PCI_FIFO_OVF = 1;
  localparam int EV_HOST_MBOX = 3;
  localparam int EV_DMA_DONE = 5;
  localparam int EV_IN_POST = 6;
  localparam int EV_OUT_POST = 7;
  localparam int EV_TGT_ABORT = 8;
  localparam int EV_MST_ABORT = 9;

  // Bits 2 and 4 are reserved; 6 and 7 are mirrors and are never stored.
  localparam logic [9:0] EVT_IMPL_MASK = 10'h3EB;
  localparam logic [9:0] EVT_STICKY_MASK = 10'h32B;
  localparam logic [9:0] EN_RESET = 10'h000;
  localparam logic [9:0] ST_RESET = 10'h000;
  localparam logic [15:0] MBOX_DATA_RESET = 16'h0000;
  localparam int MIRROR_SRC_BIT = 3;

  typedef struct packed {
    logic local_fifo_ovf;
    logic pci_fifo_ovf;
    logic host_mbox;
    logic dma_done;
    logic tgt_abort;
    logic mst_abort;
  } evt_pulse_t;

  typedef struct packed {
    logic [31:0] inbound;
    logic [31:0] outbound;
  } fifo_stat_t;

endpackage : irq_mailbox_pkg

/* File: local_irq_and_mailbox.sv */
// Local interrupt enable/status register and local-to-host mailbox behind an Avalon-MM slave.
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module local_irq_and_mailbox
  import irq_mailbox_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic soft_reset,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic avs_readdatavalid,
  input wire evt_pulse_t evt_pulse,
  input wire fifo_stat_t fifo_stat,
  input wire logic host_irq_clear,
  output logic local_irq,
  output logic host_mbox_irq,
  output logic [15:0] host_mbox_data
);

  ////////////////////////////////////////////////////////////////////////////
  logic [9:0] en_r;
  logic [9:0] st_r;
  logic [9:0] st_view;
  logic [9:0] evt_set;
  logic [9:0] wr_clear;
  logic [15:0] mbox_data_r;
  logic host_irq_r;
  logic ack_r;
  logic [31:0] rdata_r;
  logic rvalid_r;
  logic req;
  logic sel_local_interrupt_enable_status;
  logic sel_mbox;

  assign req = (avs_read | avs_write) & ~ack_r;
  assign sel_local_interrupt_enable_status = (avs_address == IRQ_REG_OFFSET);
  assign sel_mbox = (avs_address == LH_MBOX_OFFSET);

  // One wait state per access: the first cycle stalls, the second completes.
  // This keeps every register side effect on exactly one edge.
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      ack_r <= 1'b0;
    else
      ack_r <= req;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Events arriving as status pulses.
  always_comb
  begin
    evt_set = '0;
    evt_set[EV_LOCAL_FIFO_OVF] = evt_pulse.local_fifo_ovf;
    evt_set[EV_PCI_FIFO_OVF] = evt_pulse.pci_fifo_ovf;
    evt_set[EV_HOST_MBOX] = evt_pulse.host_mbox;
    evt_set[EV_DMA_DONE] = evt_pulse.dma_done;
    evt_set[EV_TGT_ABORT] = evt_pulse.tgt_abort;
    evt_set[EV_MST_ABORT] = evt_pulse.mst_abort;
  end

  always_comb
  begin
    wr_clear = '0;
    if (ack_r && avs_write && sel_local_interrupt_enable_status && avs_byteenable[0])
      wr_clear[7:0] = avs_writedata[7:0];
    if (ack_r && avs_write && sel_local_interrupt_enable_status && avs_byteenable[1])
      wr_clear[9:8] = avs_writedata[9:8];
  end

  // A new event in the same cycle as its clear wins, so nothing is lost.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      st_r <= ST_RESET;
    else
    begin
      st_r <= ((st_r & ~wr_clear) | evt_set) & EVT_STICKY_MASK;
      if (soft_reset)
        st_r[EV_HOST_MBOX] <= 1'b0;
    end
  end

  always_comb
  begin
    st_view = st_r & EVT_IMPL_MASK;
    st_view[EV_IN_POST] = fifo_stat.inbound[MIRROR_SRC_BIT];
    st_view[EV_OUT_POST] = fifo_stat.outbound[MIRROR_SRC_BIT];
  end

  // Soft reset leaves the enables alone.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      en_r <= EN_RESET;
    else if (ack_r && avs_write && sel_local_interrupt_enable_status)
    begin
      if (avs_byteenable[2])
        en_r[7:0] <= avs_writedata[EN_LSB+7:EN_LSB] & EVT_IMPL_MASK[7:0];
      if (avs_byteenable[3])
        en_r[9:8] <= avs_writedata[EN_MSB:EN_LSB+8];
    end
  end

  // Enabled status bits drive the local interrupt line.
  assign local_irq = |(st_view & en_r);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      mbox_data_r <= MBOX_DATA_RESET;
    else if (ack_r && avs_write && sel_mbox)
    begin
      if (avs_byteenable[0])
        mbox_data_r[7:0] <= avs_writedata[7:0];
      if (avs_byteenable[1])
        mbox_data_r[15:8] <= avs_writedata[15:8];
    end
  end

  assign host_mbox_data = mbox_data_r;

  // The host-side clear comes from the host status register outside.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      host_irq_r <= 1'b0;
    else if (ack_r && avs_write && sel_mbox && avs_byteenable[3] && avs_writedata[MBOX_IRQ_BIT])
      host_irq_r <= 1'b1;
    else if (host_irq_clear)
      host_irq_r <= 1'b0;
  end

  assign host_mbox_irq = host_irq_r;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata_r <= 32'h0000_0000;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rvalid_r <= ack_r & avs_read;
      if (ack_r && avs_read)
      begin
        if (sel_local_interrupt_enable_status)
          rdata_r <= {6'h00, en_r, 6'h00, st_view};
        else if (sel_mbox)
          rdata_r <= {16'h0000, mbox_data_r};
        else
          rdata_r <= 32'h0000_0000;
      end
    end
  end

  // Read data is also presented on the completing edge, combinationally.
  always_comb
  begin
    avs_readdata = rdata_r;
    if (ack_r && avs_read)
    begin
      if (sel_local_interrupt_enable_status)
        avs_readdata = {6'h00, en_r, 6'h00, st_view};
      else if (sel_mbox)
        avs_readdata = {16'h0000, mbox_data_r};
      else
        avs_readdata = 32'h0000_0000;
    end
  end

  assign avs_readdatavalid = rvalid_r;

endmodule : local_irq_and_mailbox

`default_nettype wire

/* File: host_side_model.sv */
// Host-side model that acknowledges the mailbox interrupt.
`timescale 1ns/1ps
`default_nettype none
module host_side_model (
  input wire logic sys_clk,
  input wire logic ack_en,
  input wire logic host_mbox_irq,
  input wire logic [15:0] host_mbox_data,
  output var logic host_irq_clear = 1'b0,
  output var logic [15:0] mbox_seen = 16'h0000
);
  // The clear is held back while ack_en is low, so the bench can watch the interrupt hold.
  always_ff @(posedge sys_clk)
  begin
    host_irq_clear <= ack_en & host_mbox_irq;
    if (host_mbox_irq)
      mbox_seen <= host_mbox_data;
  end
endmodule : host_side_model
`default_nettype wire

/* File: irq_mailbox_checker.sv */
// Port assertions for the local interrupt and mailbox block.
`timescale 1ns/1ps
`default_nettype none
module irq_mailbox_checker
  import irq_mailbox_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic avs_readdatavalid,
  input wire fifo_stat_t fifo_stat,
  input wire logic host_irq_clear,
  input wire logic local_irq,
  input wire logic host_mbox_irq,
  input wire logic [15:0] host_mbox_data
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  wire logic rd = avs_read & ~avs_waitrequest & (avs_address == IRQ_REG_OFFSET);
  wire logic mw = avs_write & ~avs_waitrequest & (avs_address == LH_MBOX_OFFSET);
  chk_one_wait: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("wait");
  chk_reset_quiet: assert property ($rose(resetn) |-> !local_irq && !host_mbox_irq) else $error("reset");
  chk_rsv_zero: assert property (rd |-> (avs_readdata & 32'hFC14FC14) == 32'h0) else $error("rsv");
  chk_mirror_bits:
    assert property (rd |-> avs_readdata[7:6] == {fifo_stat.outbound[3], fifo_stat.inbound[3]})
    else $error("mirror");
  chk_irq_match:
    assert property (rd |-> local_irq == |(avs_readdata[25:16] & avs_readdata[9:0]))
    else $error("irq");
  chk_rvalid_after: assert property (avs_read && !avs_waitrequest |=> avs_readdatavalid) else $error("rvalid");
  chk_mbox_set: assert property (mw && avs_byteenable[3] && avs_writedata[24] |=> host_mbox_irq) else $error("set");
  chk_mbox_hold: assert property (host_mbox_irq && !host_irq_clear |=> host_mbox_irq) else $error("hold");
  chk_mbox_data:
    assert property (mw && avs_byteenable[1:0] == 2'h3 |=> host_mbox_data == $past(avs_writedata[15:0]))
    else $error("data");
  cover property (rd && local_irq);
  cover property (host_irq_clear ##1 !host_mbox_irq);
  cover property (mw);
endmodule : irq_mailbox_checker
bind local_irq_and_mailbox irq_mailbox_checker i_chk (.*);
`default_nettype wire

/* File: testbench.sv */
// Self-checking testbench for the local interrupt and mailbox block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import irq_mailbox_pkg::*;
  logic sys_clk = 1'b0, resetn = 1'b0, soft_reset = 1'b0, avs_read = 1'b0, avs_write = 1'b0, ack_en = 1'b0;
  logic [11:0] avs_address = 12'h000;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [3:0] avs_byteenable = 4'h0;
  evt_pulse_t evt_pulse = '0;
  fifo_stat_t fifo_stat = '0;
  logic avs_waitrequest, avs_readdatavalid, local_irq, host_mbox_irq, host_irq_clear;
  logic [15:0] host_mbox_data, mbox_seen;
  int failures = 0, checks_done = 0;
  always #12.5 sys_clk = ~sys_clk;
  local_irq_and_mailbox i_dut (.*);
  host_side_model i_host (.*);
  task final_report;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // The request stands until the rising edge that sees waitrequest low; read data is taken there.
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] b);
    int n;
    @(posedge sys_clk);
    {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} <= {~w, w, a, d, b};
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0)
    begin
      failures++;
      final_report;
    end
    q = avs_readdata;
    {avs_read, avs_write} <= 2'b00;
    @(negedge sys_clk);
  endtask : bus
  task pulse(input evt_pulse_t p);
    @(posedge sys_clk);
    evt_pulse <= p;
    @(posedge sys_clk);
    evt_pulse <= '0;
    @(negedge sys_clk);
  endtask : pulse
  task t_reset;
    bus(0, IRQ_REG_OFFSET, 32'h0, 4'hF);
    chk("int reg", 32'h0, q);
    bus(0, 12'h4FC, 32'h0, 4'hF);
    chk("unmapped", 32'h0, q);
    bus(1, IRQ_REG_OFFSET, 32'hFFFFFFFF, 4'hC);
    bus(0, IRQ_REG_OFFSET, 32'h0, 4'hF);
    chk("enables", 32'h03EB0000, q);
    $display("test reset done");
  endtask : t_reset
  task t_events;
    int pos [6] = '{0, 1, 3, 5, 8, 9};
    for (int i = 0; i < 6; i++)
    begin
      pulse(evt_pulse_t'(6'h20 >> i));
      chk("irq", 32'h1, local_irq);
      bus(0, IRQ_REG_OFFSET, 32'h0, 4'hF);
      chk("status", 32'h03EB0000 | (32'h1 << pos[i]), q);
      bus(1, IRQ_REG_OFFSET, 32'h1 << pos[i], 4'h3);
      chk("clear", 32'h0, local_irq);
    end
    @(posedge sys_clk);
    fifo_stat <= '{inbound: 32'h8, outbound: 32'h8};
    bus(1, IRQ_REG_OFFSET, 32'hC0, 4'h3);
    bus(0, IRQ_REG_OFFSET, 32'h0, 4'hF);
    chk("mirror", 32'h03EB00C0, q);
    $display("test events done");
  endtask : t_events
  task t_mask;
    @(posedge sys_clk);
    fifo_stat <= '0;
    bus(1, IRQ_REG_OFFSET, 32'h0, 4'hC);
    pulse(evt_pulse_t'(6'h0C));
    chk("masked", 32'h0, local_irq);
    @(posedge sys_clk);
    soft_reset <= 1'b1;
    @(posedge sys_clk);
    soft_reset <= 1'b0;
    bus(0, IRQ_REG_OFFSET, 32'h0, 4'hF);
    chk("soft", 32'h20, q);
    $display("test mask done");
  endtask : t_mask
  task t_mbox;
    int n;
    bus(1, LH_MBOX_OFFSET, 32'h0100A55A, 4'hF);
    chk("hirq", 32'h1, host_mbox_irq);
    bus(0, LH_MBOX_OFFSET, 32'h0, 4'hF);
    chk("mbox", 32'h0000A55A, q);
    chk("hold", 32'h1, host_mbox_irq);
    @(posedge sys_clk);
    ack_en <= 1'b1;
    for (n = 0; n < 8 && host_mbox_irq !== 1'b0; n++)
      @(negedge sys_clk);
    chk("hclr", 32'h0, host_mbox_irq);
    chk("seen", 32'hA55A, mbox_seen);
    $display("test mailbox done");
  endtask : t_mbox
  initial
  begin
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset;
    t_events;
    t_mask;
    t_mbox;
    final_report;
  end
endmodule : testbench
`default_nettype wire
